/* fwp_pkg.sv */
/*
  fwp_pkg: constants shared by the flash write-protect and register block.
  assumes a command decoder upstream hands over decoded opcodes and addresses.
*/
`default_nettype none
package fwp_pkg;
  localparam logic [7:0] OP_PROG_1 = 8'h02;
  localparam logic [7:0] OP_PROG_4A = 8'h32;
  localparam logic [7:0] OP_PROG_4B = 8'h38;
  localparam logic [7:0] OP_SE_A = 8'hd7;
  localparam logic [7:0] OP_SE_B = 8'h20;
  localparam logic [7:0] OP_BE32 = 8'h52;
  localparam logic [7:0] OP_BE64 = 8'hd8;
  localparam logic [7:0] OP_CE_A = 8'hc7;
  localparam logic [7:0] OP_CE_B = 8'h60;
  localparam logic [7:0] OP_WSTAT = 8'h01;
  localparam logic [7:0] OP_WFUNC = 8'h42;
  localparam logic [7:0] OP_RPNV = 8'h65;
  localparam logic [7:0] OP_XRPNV = 8'h85;
  localparam logic [7:0] OP_ROW_ERASE = 8'h64;
  localparam logic [7:0] OP_IRPG = 8'h62;
  localparam logic [7:0] OP_ABW = 8'h15;
  localparam logic [7:0] OP_WLSET = 8'h06;
  localparam logic [7:0] OP_WLCLR = 8'h04;
  localparam logic [7:0] OP_SUSP = 8'h75;
  localparam logic [7:0] OP_RESUME = 8'h7a;
  // status bit positions
  localparam int ST_BUSY = 0;
  localparam int ST_WL = 1;
  localparam int ST_BP_LO = 2;
  localparam int ST_QUAD = 6;
  localparam int ST_LOCK = 7;
  // function bit positions
  localparam int FN_RSTDIS = 0;
  localparam int FN_BOTTOM = 1;
  localparam int FN_PROG_SUSP = 2;
  localparam int FN_ERASE_SUSP = 3;
  localparam int FN_IRL_LO = 4;
  localparam int BLK_W = 7;
  localparam int ADDR_W = 23;
  localparam logic [7:0] NPROT_ALL = 8'h80;
  localparam logic [7:0] NPROT_NONE = 8'h00;
  localparam logic [7:0] BLK_LAST = 8'h7f;
  localparam logic [7:0] STAT_RST = 8'h00;
  localparam logic [7:0] FUNC_RST = 8'h00;
  localparam logic [3:0] FN_OTP_MASK = 4'hf;
  localparam int OP_CYCLES = 4;
  typedef enum logic [1:0] {OP_NONE, OP_PROG, OP_ERASE, OP_REGW} fwp_op_t;
endpackage : fwp_pkg
`default_nettype wire

/* fwp_core.sv */
/*
  fwp_core: status/function registers, write latch, block protection and
  suspend flags of a serial flash. assumes cmd_valid is a one-cycle pulse from a
  decoder on clk_sys (serial clock domain), with address and data held alongside.
  op_done_i ends the running array or register operation.
*/
`timescale 1ns/1ps
`default_nettype none
module fwp_core #(
  parameter logic RSTDIS_DEFAULT = 1'b0
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_op,
  input wire logic [22:0] cmd_addr,
  input wire logic [7:0] cmd_data,
  input wire logic [1:0] cmd_row,
  input wire logic op_done_i,
  input wire logic wp_n_pin,
  output logic [7:0] flash_status,
  output logic [7:0] flash_function_config,
  output logic op_start,
  output logic op_reject,
  output logic pins_are_data,
  output logic hold_reset_shared
);
  logic wp_s1_q, wp_s2_q;
  logic [7:0] stat_q, stat_d;
  logic [7:0] func_q, func_d;
  fwp_pkg::fwp_op_t op_q, op_d;
  logic start_q, start_d, rej_q, rej_d, susp_q, susp_d;
  logic [3:0] bp;
  logic [fwp_pkg::BLK_W-1:0] blk;
  logic in_prot, needs_wl, is_prog, is_erase, is_ce, stat_frozen, row_locked;
  logic [fwp_pkg::BLK_W:0] nprot;

  always_ff @(posedge clk_sys)
  begin
    wp_s1_q <= wp_n_pin;
    wp_s2_q <= wp_s1_q;
  end

  assign bp = stat_q[fwp_pkg::ST_BP_LO +: 4];
  assign blk = cmd_addr[fwp_pkg::ADDR_W-1 -: fwp_pkg::BLK_W];

  always_comb
  begin
    if (bp[3])
      nprot = fwp_pkg::NPROT_ALL;
    else if (bp[2:0] == 3'h0)
      nprot = fwp_pkg::NPROT_NONE;
    else
      nprot = 8'(8'h01 << (bp[2:0] - 3'h1));
    if (func_q[fwp_pkg::FN_BOTTOM])
      in_prot = {1'b0, blk} < nprot;
    else
      in_prot = ({1'b0, blk} + nprot) > fwp_pkg::BLK_LAST;
  end

  always_comb
  begin
    is_prog = 1'b0;
    is_erase = 1'b0;
    is_ce = 1'b0;
    needs_wl = 1'b1;
    case (cmd_op)
      fwp_pkg::OP_PROG_1, fwp_pkg::OP_PROG_4A, fwp_pkg::OP_PROG_4B:
        is_prog = 1'b1;
      fwp_pkg::OP_SE_A, fwp_pkg::OP_SE_B, fwp_pkg::OP_BE32, fwp_pkg::OP_BE64:
        is_erase = 1'b1;
      fwp_pkg::OP_CE_A, fwp_pkg::OP_CE_B:
        is_ce = 1'b1;
      fwp_pkg::OP_WSTAT, fwp_pkg::OP_WFUNC, fwp_pkg::OP_RPNV:
        needs_wl = 1'b1;
      fwp_pkg::OP_XRPNV, fwp_pkg::OP_ROW_ERASE, fwp_pkg::OP_IRPG, fwp_pkg::OP_ABW:
        needs_wl = 1'b1;
      default:
        needs_wl = 1'b0;
    endcase
    // pin is seen two edges late, so a write right after it drops still passes
    stat_frozen = stat_q[fwp_pkg::ST_LOCK] && !wp_s2_q;
    row_locked = func_q[fwp_pkg::FN_IRL_LO + 32'(cmd_row)];
  end

  always_comb
  begin
    stat_d = stat_q;
    func_d = func_q;
    op_d = op_q;
    susp_d = susp_q;
    start_d = 1'b0;
    rej_d = 1'b0;
    if (op_q != fwp_pkg::OP_NONE && op_done_i)
    begin
      stat_d[fwp_pkg::ST_BUSY] = 1'b0;
      stat_d[fwp_pkg::ST_WL] = 1'b0;
      op_d = fwp_pkg::OP_NONE;
    end
    if (cmd_valid)
    begin
      if (stat_q[fwp_pkg::ST_BUSY])
      begin
        if (cmd_op == fwp_pkg::OP_SUSP && !op_done_i)
        begin
          // suspend parks a program or erase op; busy drops so other work may run
          if (op_q == fwp_pkg::OP_PROG)
            func_d[fwp_pkg::FN_PROG_SUSP] = 1'b1;
          if (op_q == fwp_pkg::OP_ERASE)
            func_d[fwp_pkg::FN_ERASE_SUSP] = 1'b1;
          if (op_q == fwp_pkg::OP_PROG || op_q == fwp_pkg::OP_ERASE)
          begin
            susp_d = op_q == fwp_pkg::OP_ERASE;
            stat_d[fwp_pkg::ST_BUSY] = 1'b0;
            op_d = fwp_pkg::OP_NONE;
          end
        end
        else
          rej_d = 1'b1;
      end
      else if (cmd_op == fwp_pkg::OP_WLSET)
        stat_d[fwp_pkg::ST_WL] = 1'b1;
      else if (cmd_op == fwp_pkg::OP_WLCLR)
        stat_d[fwp_pkg::ST_WL] = 1'b0;
      else if (cmd_op == fwp_pkg::OP_RESUME
        && (func_q[fwp_pkg::FN_PROG_SUSP] || func_q[fwp_pkg::FN_ERASE_SUSP]))
      begin
        // resume re-enters whichever operation was parked last
        func_d[fwp_pkg::FN_PROG_SUSP] = 1'b0;
        func_d[fwp_pkg::FN_ERASE_SUSP] = 1'b0;
        stat_d[fwp_pkg::ST_BUSY] = 1'b1;
        op_d = susp_q ? fwp_pkg::OP_ERASE : fwp_pkg::OP_PROG;
      end
      else if (needs_wl && !stat_q[fwp_pkg::ST_WL])
        rej_d = 1'b1;
      else if (((is_prog || is_erase) && in_prot)
        || (is_ce && bp != 4'h0)
        || (cmd_op == fwp_pkg::OP_WSTAT && stat_frozen)
        || (cmd_op == fwp_pkg::OP_IRPG && row_locked))
        rej_d = 1'b1;
      else if (needs_wl)
      begin
        start_d = 1'b1;
        stat_d[fwp_pkg::ST_BUSY] = 1'b1;
        op_d = is_prog ? fwp_pkg::OP_PROG
          : (is_erase || is_ce) ? fwp_pkg::OP_ERASE : fwp_pkg::OP_REGW;
        if (cmd_op == fwp_pkg::OP_WSTAT)
          stat_d[7:fwp_pkg::ST_BP_LO] = cmd_data[7:fwp_pkg::ST_BP_LO];
        if (cmd_op == fwp_pkg::OP_WFUNC)
        begin
          func_d[fwp_pkg::FN_RSTDIS] = func_q[fwp_pkg::FN_RSTDIS] | cmd_data[fwp_pkg::FN_RSTDIS];
          func_d[fwp_pkg::FN_BOTTOM] = func_q[fwp_pkg::FN_BOTTOM] | cmd_data[fwp_pkg::FN_BOTTOM];
          func_d[7:fwp_pkg::FN_IRL_LO] = func_q[7:fwp_pkg::FN_IRL_LO]
            | (cmd_data[7:fwp_pkg::FN_IRL_LO] & fwp_pkg::FN_OTP_MASK);
        end
      end
    end
    // parts shipped with the reset pin disabled show a one here from the first edge out of reset
    func_d[fwp_pkg::FN_RSTDIS] = func_d[fwp_pkg::FN_RSTDIS] | RSTDIS_DEFAULT;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      stat_q <= fwp_pkg::STAT_RST;
      func_q <= fwp_pkg::FUNC_RST;
      op_q <= fwp_pkg::OP_NONE;
      susp_q <= 1'b0;
      start_q <= 1'b0;
      rej_q <= 1'b0;
      pins_are_data <= 1'b0;
      hold_reset_shared <= 1'b0;
    end
    else
    begin
      stat_q <= stat_d;
      func_q <= func_d;
      op_q <= op_d;
      susp_q <= susp_d;
      start_q <= start_d;
      rej_q <= rej_d;
      // pin routing tracks the register copy edge for edge
      pins_are_data <= stat_d[fwp_pkg::ST_QUAD];
      hold_reset_shared <= func_d[fwp_pkg::FN_RSTDIS];
    end
  end

  assign flash_status = stat_q;
  assign flash_function_config = func_q;
  assign op_start = start_q;
  assign op_reject = rej_q;

  // protection and latch checks
  uncommitted_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    cmd_valid && !stat_q[0] && !stat_q[1] && needs_wl |=> op_reject && !op_start)
    else $error("write without latch not refused");
  prot_block_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    cmd_valid && !stat_q[0] && (is_prog || is_erase) && in_prot |=> !op_start)
    else $error("protected block started");
  chip_erase_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    cmd_valid && is_ce && bp != 4'h0 |=> !op_start)
    else $error("chip erase ran with protection");
  ce_open_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    cmd_valid && !stat_q[0] && stat_q[1] && is_ce && bp == 4'h0 |=> op_start)
    else $error("open chip erase refused");
  prot_all_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    cmd_valid && !stat_q[0] && (is_prog || is_erase) && bp[3] |=> op_reject)
    else $error("whole array protection missed");
  prot_top_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    cmd_valid && !stat_q[0] && (is_prog || is_erase) && !func_q[1] && bp == 4'h3 && blk >= 7'h7c
    |=> op_reject)
    else $error("top region write not refused");
  prot_bottom_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    cmd_valid && !stat_q[0] && (is_prog || is_erase) && func_q[1] && bp == 4'h1 && blk == 7'h00
    |=> op_reject)
    else $error("bottom region write not refused");
  row_lock_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    cmd_valid && !stat_q[0] && cmd_op == fwp_pkg::OP_IRPG && row_locked |=> op_reject)
    else $error("locked row program not refused");
  latch_set_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    cmd_valid && !stat_q[0] && cmd_op == fwp_pkg::OP_WLSET |=> stat_q[1])
    else $error("latch not set");
  latch_clr_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    cmd_valid && !stat_q[0] && cmd_op == fwp_pkg::OP_WLCLR |=> !stat_q[1])
    else $error("latch not cleared");
  latch_quiet_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    cmd_valid && !stat_q[0] && (cmd_op == fwp_pkg::OP_WLSET || cmd_op == fwp_pkg::OP_WLCLR) |=> !op_start && !op_reject)
    else $error("latch command pulsed");
  // register and flag checks
  stat_frozen_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    cmd_valid && cmd_op == fwp_pkg::OP_WSTAT && stat_frozen |=> $stable(stat_q[7:2]))
    else $error("frozen status changed");
  reg_write_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    cmd_valid && !stat_q[0] && stat_q[1] && cmd_op == fwp_pkg::OP_WSTAT && !stat_frozen
    |=> stat_q[7:2] == $past(cmd_data[7:2]))
    else $error("status write lost");
  quad_pin_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    pins_are_data == stat_q[6])
    else $error("pin function differs from quad bit");
  hold_shared_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    hold_reset_shared == func_q[0])
    else $error("reset pin routing differs from bit");
  otp_sticky_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    func_q[1] |=> func_q[1])
    else $error("otp bit cleared");
  otp_rows_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    func_q[7:4] != 4'h0 |=> (func_q[7:4] & $past(func_q[7:4])) == $past(func_q[7:4]))
    else $error("row lock cleared");
  busy_done_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    op_q != fwp_pkg::OP_NONE && op_done_i && !cmd_valid |=> !stat_q[0] && !stat_q[1])
    else $error("busy or latch stuck after done");
  busy_ignore_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    stat_q[0] && cmd_valid && cmd_op != fwp_pkg::OP_SUSP |=> op_reject)
    else $error("command accepted while busy");
  busy_hold_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    stat_q[0] && !op_done_i && !cmd_valid |=> stat_q[0])
    else $error("busy dropped early");
  start_busy_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    op_start |-> stat_q[0])
    else $error("started without busy");
  program_suspended_flag_set_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    cmd_valid && cmd_op == fwp_pkg::OP_SUSP && op_q == fwp_pkg::OP_PROG && !op_done_i |=> func_q[2])
    else $error("program suspend flag not set");
  erase_suspended_flag_set_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    cmd_valid && cmd_op == fwp_pkg::OP_SUSP && op_q == fwp_pkg::OP_ERASE && !op_done_i |=> func_q[3])
    else $error("erase suspend flag not set");
  resume_clr_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    cmd_valid && !stat_q[0] && cmd_op == fwp_pkg::OP_RESUME && func_q[3:2] != 2'h0
    |=> stat_q[0] && func_q[3:2] == 2'h0)
    else $error("resume left flags or idle");
  // scenario covers
  start_cov: cover property (@(posedge clk_sys) disable iff (!resetn) op_start);
  rej_cov: cover property (@(posedge clk_sys) disable iff (!resetn) op_reject && in_prot);
  susp_cov: cover property (@(posedge clk_sys) disable iff (!resetn) func_q[3]);
  program_suspended_flag_cov: cover property (@(posedge clk_sys) disable iff (!resetn) func_q[2]);
  frozen_cov: cover property (@(posedge clk_sys) disable iff (!resetn) cmd_valid && stat_frozen);
endmodule : fwp_core
`default_nettype wire

/* fwp_host.sv */
/*
  fwp_host: host controller model, issues decoded commands to fwp_core.
  assumes one testbench process calls its tasks, all on clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none
module fwp_host (
  input wire logic clk_sys,
  output logic cmd_valid,
  output logic [7:0] cmd_op,
  output logic [22:0] cmd_addr,
  output logic [7:0] cmd_data,
  output logic [1:0] cmd_row,
  output logic op_done_i,
  output logic wp_n_pin
);
  initial
  begin
    cmd_valid = 1'b0;
    cmd_op = 8'h00;
    cmd_addr = 23'h0;
    cmd_data = 8'h00;
    cmd_row = 2'h0;
    op_done_i = 1'b0;
    wp_n_pin = 1'b1;
  end
  // released lines show the inverse, so a stale value never looks valid
  task issue(input logic [7:0] op, input logic [22:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_addr <= a;
    cmd_data <= d;
    cmd_row <= a[1:0];
    @(posedge clk_sys);
    cmd_valid <= 1'b0;
    cmd_op <= ~op;
    cmd_addr <= ~a;
    cmd_data <= ~d;
    cmd_row <= ~a[1:0];
  endtask : issue
  task finish;
    @(posedge clk_sys);
    op_done_i <= 1'b1;
    @(posedge clk_sys);
    op_done_i <= 1'b0;
  endtask : finish
endmodule : fwp_host
`default_nettype wire

/* tb.sv */
/*
  tb: self-checking bench for fwp_core, driven through fwp_host.
  assumes a start or reject pulse follows every write-type command.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic cmd_valid, op_done_i, wp_n_pin, op_start, op_reject, pins_are_data, hold_reset_shared;
  logic [7:0] cmd_op, cmd_data, flash_status, flash_function_config;
  logic [22:0] cmd_addr;
  logic [1:0] cmd_row;
  int fails = 0;
  int num_checks = 0;
  int seed = 29471;
  logic exp_q[$];
  logic [7:0] ops [16] = '{8'h02, 8'h32, 8'h38, 8'hd7, 8'h20, 8'h52, 8'hd8, 8'hc7, 8'h60,
                           8'h01, 8'h42, 8'h65, 8'h85, 8'h64, 8'h62, 8'h15};
  always #10 clk_sys = ~clk_sys;
  fwp_host host_u (.clk_sys(clk_sys), .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
    .cmd_data(cmd_data), .cmd_row(cmd_row), .op_done_i(op_done_i), .wp_n_pin(wp_n_pin));
  fwp_core dut_u (.clk_sys(clk_sys), .resetn(resetn), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
    .cmd_addr(cmd_addr), .cmd_data(cmd_data), .cmd_row(cmd_row), .op_done_i(op_done_i),
    .wp_n_pin(wp_n_pin), .flash_status(flash_status), .flash_function_config(flash_function_config),
    .op_start(op_start), .op_reject(op_reject), .pins_are_data(pins_are_data),
    .hold_reset_shared(hold_reset_shared));
  task tally_and_finish;
    if (fails == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : tally_and_finish
  task chk_pulse(input logic g, input logic e);
    num_checks++;
    if (g !== e)
    begin
      fails++;
      $display("Error %0t: start/reject outcome wrong", $time);
    end
  endtask : chk_pulse
  task chk_reg(input logic [7:0] g, input logic [7:0] e);
    num_checks++;
    if (g !== e)
    begin
      fails++;
      $display("Error %0t: register got %h want %h", $time, g, e);
    end
  endtask : chk_reg
  task cmd(input logic [7:0] op, input logic [22:0] a, input logic [7:0] d, input logic e);
    exp_q.push_back(e);
    host_u.issue(op, a, d);
  endtask : cmd
  task wl;
    host_u.issue(8'h06, 23'h0, 8'h00);
  endtask : wl
  task run(input logic [7:0] op, input logic [22:0] a, input logic [7:0] d);
    wl();
    cmd(op, a, d, 1'b1);
    host_u.finish();
    #1;
  endtask : run
  always @(negedge clk_sys)
    if (resetn && (op_start === 1'b1 || op_reject === 1'b1))
    begin
      if (exp_q.size() == 0)
        chk_pulse(1'b1, 1'b0);
      else
        chk_pulse(op_start, exp_q.pop_front());
    end
  initial
  begin
    #200000;
    fails++;
    tally_and_finish();
  end
  initial
  begin
    repeat (4) @(posedge clk_sys);
    resetn <= 1'b1;
    #1;
    chk_reg(flash_status, 8'h00);
    chk_reg(flash_function_config, 8'h00);
    foreach (ops[i]) cmd(ops[i], 23'($random(seed)), 8'h00, 1'b0);
    for (int i = 0; i < 9; i++)
    begin
      run(ops[i], 23'($random(seed)), 8'h00);
      chk_reg(flash_status, 8'h00);
    end
    wl();
    host_u.issue(8'h04, 23'h0, 8'h00);
    cmd(8'h02, 23'h0, 8'h00, 1'b0);
    run(8'h01, 23'h0, 8'hcc);
    chk_reg(flash_status, 8'hcc);
    chk_reg({7'h0, pins_are_data}, 8'h01);
    // code 3 on top: blocks 124 to 127 closed, 123 open
    wl();
    cmd(8'hd8, {7'd124, 16'($random(seed))}, 8'h00, 1'b0);
    cmd(8'hc7, 23'h0, 8'h00, 1'b0);
    cmd(8'h20, {7'd123, 16'($random(seed))}, 8'h00, 1'b1);
    host_u.finish();
    host_u.wp_n_pin <= 1'b0;
    repeat (3) @(posedge clk_sys);
    wl();
    cmd(8'h01, 23'h0, 8'h00, 1'b0);
    host_u.wp_n_pin <= 1'b1;
    repeat (3) @(posedge clk_sys);
    run(8'h01, 23'h0, 8'h04);
    chk_reg(flash_status, 8'h04);
    run(8'h42, 23'h0, 8'h03);
    chk_reg({7'h0, hold_reset_shared}, 8'h01);
    run(8'h42, 23'h0, 8'h10);
    chk_reg(flash_function_config, 8'h13);
    wl();
    cmd(8'h52, {7'd0, 16'($random(seed))}, 8'h00, 1'b0);
    cmd(8'h62, 23'h0, 8'h00, 1'b0);
    cmd(8'h02, {7'd1, 16'($random(seed))}, 8'h00, 1'b1);
    cmd(8'h02, 23'h0, 8'h00, 1'b0);
    host_u.finish();
    run(8'h62, 23'h1, 8'h00);
    wl();
    cmd(8'h02, {7'd2, 16'($random(seed))}, 8'h00, 1'b1);
    host_u.issue(8'h75, 23'h0, 8'h00);
    #1;
    chk_reg(flash_function_config, 8'h17);
    host_u.issue(8'h7a, 23'h0, 8'h00);
    #1;
    chk_reg(flash_function_config, 8'h13);
    host_u.finish();
    wl();
    cmd(8'h20, {7'd2, 16'($random(seed))}, 8'h00, 1'b1);
    host_u.issue(8'h75, 23'h0, 8'h00);
    #1;
    chk_reg(flash_function_config, 8'h1b);
    host_u.issue(8'h7a, 23'h0, 8'h00);
    #1;
    chk_reg(flash_function_config, 8'h13);
    host_u.finish();
    #1;
    chk_reg(flash_status, 8'h04);
    repeat (3) @(posedge clk_sys);
    tally_and_finish();
  end
endmodule : tb
`default_nettype wire
